// ### view_resizer_apply.sv
// apply stage: immediate or vsync-deferred take-over of written values
`timescale 1ns/1ps
module view_resizer_apply
   import view_resizer_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   view_resizer_if.apply bus
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] start_x;
      logic [15:0] rate;
   } act_t;
   act_t s_reg;
   act_t s_next;
   logic defer;
   assign defer = bus.ctrl[CTRL_DEFER_BIT];
   // take new values now, or hold old ones until the vsync
   always_comb begin
      s_next = s_reg;
      if (!defer || bus.vsync) begin // R2
         s_next.ctrl = bus.ctrl;
         s_next.start_x = bus.start_x;
         s_next.rate = bus.rate;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_reg <= '{CTRL_RESET, START_X_RESET, RATE_RESET};
      end else begin
         s_reg <= s_next;
      end
   end
   assign bus.enable = s_reg.ctrl[CTRL_ENABLE_BIT]; // R4
   assign bus.start_x_act = s_reg.start_x[START_X_WIDTH-1:0]; // R7
   assign bus.rate_h = s_reg.rate[7:0];
   // shared rate or independent vertical rate
   assign bus.rate_v = s_reg.ctrl[CTRL_INDEP_BIT] ? s_reg.rate[15:8] // R8
      : s_reg.rate[7:0]; // R10
   assign bus.busy = (s_reg != '{bus.ctrl, bus.start_x, bus.rate});
   a_defer_holds: assert property (@(posedge clock) disable iff (rst)
      defer && !bus.vsync && $stable(bus.ctrl) |=> $stable(s_reg.start_x))
      else $error("deferred value applied without vsync"); // R2
   a_immediate_take: assert property (@(posedge clock) disable iff (rst)
      !defer |=> s_reg.start_x == $past(bus.start_x))
      else $error("immediate value not applied"); // R2
endmodule // view_resizer_apply

// ### view_resizer_control.sv
// top: avalon register slave, sync of vsync, resizer clock gate
`timescale 1ns/1ps
// What this block does and what software must keep to
// R1 - software must not write reserved offsets 2432h to 243Eh
// R2 - deferred bit 0 applies writes at once; 1 waits for next vsync
// R3 - software clears deferred bit while camera mode field is 001b
// R4 - view resizer runs only while control bit 0 is 1
// R5 - software never enables view and capture resizers together
// R6 - resizer clock gated off when both resizer enables are 0
// R7 - 11-bit start x field, upper bits in register bits 10 to 8
// R8 - independent bit 1 takes vertical rate from rate bits 15 to 8
// R9 - software keeps trimmed, scaled output size even
// R10 - independent bit 0 uses low rate byte for both directions
module view_resizer_control
   import view_resizer_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [1:0] byteenable,
   input wire logic [15:0] writedata,
   output logic [15:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   input wire logic vsync_pin,
   input wire logic capture_enable,
   output logic resizer_enable,
   output logic resizer_clock_en,
   output logic [10:0] start_x,
   output logic [7:0] rate_h,
   output logic [7:0] rate_v
);
   ///////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] start_x;
      logic [15:0] rate;
      logic [15:0] rdata;
      logic [1:0] resp;
      logic ack;
      logic [2:0] vs_sync;
      logic vs_level;
      logic clk_en;
   } state_t;
   state_t s_reg;
   state_t s_next;
   view_resizer_if link ();
   logic req;
   logic [15:0] wmask;
   logic vs_rise;
   logic rsvd_hit;
   assign req = (read || write) && !s_reg.ack;
   assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign rsvd_hit = address >= RSVD_LO && address <= RSVD_HI;
   // vsync edge once second and third stages agree on high
   assign vs_rise = s_reg.vs_sync[1] && s_reg.vs_sync[2]
      && !s_reg.vs_level;
   ///////////////////////////////////////////////////////////////////
   // register decode, one wait cycle per access
   always_comb begin
      s_next = s_reg;
      s_next.ack = req;
      s_next.vs_sync = {s_reg.vs_sync[1:0], vsync_pin};
      if (s_reg.vs_sync[1] == s_reg.vs_sync[2]) begin
         s_next.vs_level = s_reg.vs_sync[2];
      end
      // clock stops when neither resizer is enabled
      s_next.clk_en = link.enable || capture_enable; // R6
      if (req) begin
         s_next.resp = 2'h0;
         s_next.rdata = 16'h0000;
         case (address)
            CTRL_OFFSET: begin
               s_next.rdata = s_reg.ctrl & 16'h0007;
               if (write) begin
                  s_next.ctrl = ((s_reg.ctrl & ~wmask)
                     | (writedata & wmask)) & 16'h0007; // R4
               end
            end
            START_X_OFFSET: begin
               s_next.rdata = s_reg.start_x;
               if (write) begin
                  s_next.start_x = ((s_reg.start_x & ~wmask)
                     | (writedata & wmask)) & 16'h07FF; // R7
               end
            end
            RATE_OFFSET: begin
               s_next.rdata = s_reg.rate;
               if (write) begin
                  s_next.rate = (s_reg.rate & ~wmask)
                     | (writedata & wmask);
               end
            end
            STATUS_OFFSET: begin
               s_next.rdata = {14'h0000, link.busy, s_reg.clk_en};
            end
            default: begin
               // reserved window writes are dropped; R1 binds software
               s_next.resp = rsvd_hit ? 2'h0 : 2'h2; // R1
            end
         endcase
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_reg <= '{CTRL_RESET, START_X_RESET, RATE_RESET, 16'h0000,
            2'h0, 1'b0, 3'h0, 1'b0, 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
   ///////////////////////////////////////////////////////////////////
   assign link.ctrl = s_reg.ctrl;
   assign link.start_x = s_reg.start_x;
   assign link.rate = s_reg.rate;
   assign link.vsync = vs_rise; // R2
   view_resizer_apply u_apply (
      .clock(clock),
      .rst(rst),
      .bus(link)
   );
   assign waitrequest = (read || write) && !s_reg.ack;
   assign readdata = s_reg.rdata;
   assign response = s_reg.resp;
   assign resizer_enable = link.enable && s_reg.clk_en; // R4
   assign resizer_clock_en = s_reg.clk_en; // R6
   assign start_x = link.start_x_act;
   assign rate_h = link.rate_h;
   assign rate_v = link.rate_v;
   ///////////////////////////////////////////////////////////////////
   a_clock_gate: assert property (@(posedge clock) disable iff (rst)
      !link.enable && !capture_enable |=> !resizer_clock_en)
      else $error("clock not gated with both enables low"); // R6
   a_disabled_idle: assert property (@(posedge clock) disable iff (rst)
      !link.enable |-> !resizer_enable)
      else $error("resizer active while disabled"); // R4
   a_start_width: assert property (@(posedge clock) disable iff (rst)
      s_reg.start_x[15:11] == 5'h00)
      else $error("start x upper bits set"); // R7
   a_indep_rate: assert property (@(posedge clock) disable iff (rst)
      u_apply.s_reg.ctrl[CTRL_INDEP_BIT] |-> rate_v == u_apply.s_reg.rate[15:8])
      else $error("vertical rate not independent"); // R8
   a_shared_rate: assert property (@(posedge clock) disable iff (rst)
      !u_apply.s_reg.ctrl[CTRL_INDEP_BIT] |-> rate_v == rate_h)
      else $error("shared rate differs"); // R10
   a_one_wait: assert property (@(posedge clock) disable iff (rst)
      (read || write) && waitrequest |=> !waitrequest || !(read || write))
      else $error("access waited more than one cycle");
   a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
      write && !waitrequest && address == CTRL_OFFSET
      && byteenable[0] |=> s_reg.ctrl == ($past(writedata) & 16'h0007))
      else $error("control write lost"); // R4
   a_rsvd_kept: assert property (@(posedge clock) disable iff (rst)
      write && rsvd_hit |=> $stable(s_reg.ctrl) && $stable(s_reg.rate)
      && $stable(s_reg.start_x))
      else $error("reserved write changed state"); // R1
   c_enable: cover property (@(posedge clock) disable iff (rst)
      $rose(resizer_enable));
   c_vsync_apply: cover property (@(posedge clock) disable iff (rst)
      link.vsync && s_reg.ctrl[CTRL_DEFER_BIT]);
   c_gate_off: cover property (@(posedge clock) disable iff (rst)
      $fell(resizer_clock_en));
endmodule // view_resizer_control

// ### view_resizer_control_tb.sv
// testbench: register access, apply timing and clock gate of the resizer
`timescale 1ns/1ps
module view_resizer_control_tb
   import view_resizer_pkg::*;
;
   logic clock, rst, read, write, vsync_pin, capture_enable;
   logic [15:0] address, writedata, readdata, q;
   logic [1:0] byteenable, response, r;
   logic waitrequest, resizer_enable, resizer_clock_en;
   logic [10:0] start_x;
   logic [7:0] rate_h, rate_v;
   int n_errors = 0;
   int checks_done = 0;

   view_resizer_control dut (.clock(clock), .rst(rst), .address(address),
      .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .response(response),
      .vsync_pin(vsync_pin), .capture_enable(capture_enable),
      .resizer_enable(resizer_enable), .resizer_clock_en(resizer_clock_en),
      .start_x(start_x), .rate_h(rate_h), .rate_v(rate_v));

   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask

   // one avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [15:0] a,
         input logic [15:0] d);
      int n;
      logic wt;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= w;
      read <= ~w;
      do begin
         #1 wt = waitrequest;
         @(posedge clock);
         n++;
      end while (wt !== 1'b0 && n < 20);
      read <= 1'b0;
      write <= 1'b0;
      #1 q = readdata;
      r = response;
      if (n >= 20) begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      bus(0, CTRL_OFFSET, 0); chk(q, CTRL_RESET);
      bus(0, RATE_OFFSET, 0); chk(q, RATE_RESET);
      chk({rate_v, rate_h}, 16'h8080);
      chk({resizer_enable, resizer_clock_en}, 16'h0000);
   endtask

   task automatic t_start_x();
      bus(1, START_X_OFFSET, 16'hFFFF); settle(3);
      chk(start_x, 16'h07FF);
      bus(0, START_X_OFFSET, 0); chk(q & 16'h07FF, 16'h07FF);
   endtask

   task automatic t_rate();
      bus(1, RATE_OFFSET, 16'h1234); settle(3);
      chk({rate_v, rate_h}, 16'h3434);
      bus(1, CTRL_OFFSET, 16'h0004); settle(3);
      chk({rate_v, rate_h}, 16'h1234);
   endtask

   task automatic t_enable();
      bus(1, CTRL_OFFSET, 16'h0001); settle(4);
      chk({resizer_enable, resizer_clock_en}, 2'h3);
      bus(1, CTRL_OFFSET, 16'h0000); settle(4);
      chk({resizer_enable, resizer_clock_en}, 2'h0);
      // capture side only raised while the view resizer is off
      @(posedge clock);
      capture_enable <= 1'b1;
      settle(3);
      chk({resizer_enable, resizer_clock_en}, 16'h0001);
      @(posedge clock);
      capture_enable <= 1'b0;
      settle(3);
      chk(resizer_clock_en, 16'h0000);
   endtask

   task automatic t_defer();
      bus(1, CTRL_OFFSET, 16'h0002);
      bus(1, START_X_OFFSET, 16'h0123); settle(8);
      chk(start_x, 16'h07FF);
      bus(0, STATUS_OFFSET, 0); chk(q, 16'h0002);
      @(posedge clock);
      vsync_pin <= 1'b1;
      settle(8);
      chk(start_x, 16'h0123);
      @(posedge clock);
      vsync_pin <= 1'b0;
      bus(1, CTRL_OFFSET, 16'h0000);
   endtask

   task automatic t_reserved();
      // reserved window is only read, never written
      bus(0, RSVD_LO, 0); chk(r, 16'h0000);
      chk(q, 16'h0000);
      bus(0, CTRL_OFFSET, 0); chk(q, 16'h0000);
      bus(0, 16'h2454, 0); chk(r, 16'h0002);
      chk(q, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock, reset and main sequence
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial begin
      rst = 1'b1; read = 1'b0; write = 1'b0; address = 16'h0000;
      writedata = 16'h0000; byteenable = 2'h3; vsync_pin = 1'b0;
      capture_enable = 1'b0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_start_x();
      t_rate();
      t_enable();
      t_defer();
      t_reserved();
      test_done();
   end
endmodule // view_resizer_control_tb

// ### view_resizer_pkg.sv
// package: register map, field positions and reset values of the view resizer
package view_resizer_pkg;
   // printed offsets (byte addresses of the register window)
   localparam logic [15:0] CTRL_OFFSET = 16'h2440;
   localparam logic [15:0] START_X_OFFSET = 16'h2444;
   localparam logic [15:0] RATE_OFFSET = 16'h244C;
   localparam logic [15:0] STATUS_OFFSET = 16'h2450;
   localparam logic [15:0] RSVD_LO = 16'h2432;
   localparam logic [15:0] RSVD_HI = 16'h243E;
   // control field positions and start x field width
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_DEFER_BIT = 1;
   localparam int CTRL_INDEP_BIT = 2;
   localparam int START_X_WIDTH = 11;
   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] START_X_RESET = 16'h0000;
   localparam logic [15:0] RATE_RESET = 16'h8080;
endpackage

// ### view_resizer_sync.sv
// interface carrying the pending settings into the apply stage
`timescale 1ns/1ps
interface view_resizer_if;
   logic [15:0] ctrl;
   logic [15:0] start_x;
   logic [15:0] rate;
   logic vsync;
   logic enable;
   logic [10:0] start_x_act;
   logic [7:0] rate_h;
   logic [7:0] rate_v;
   logic busy;
   modport regs (output ctrl, output start_x, output rate, output vsync,
      input enable, input start_x_act, input rate_h, input rate_v,
      input busy);
   modport apply (input ctrl, input start_x, input rate, input vsync,
      output enable, output start_x_act, output rate_h, output rate_v,
      output busy);
endinterface
